// ==== hdl/rbt_pkg.sv ====
// Shared types, constants and helpers for the registered bus transceiver.
package rbt_pkg;

	localparam int RBT_WIDTH = 8;
	localparam int RBT_LOG_DEPTH = 8;
	localparam int RBT_SYNC_STAGES = 2;
	localparam logic [7:0] RBT_REG_RST = 8'h00;
	localparam logic RBT_BIT_RST = 1'b0;

	typedef struct packed {
		logic drive_gate_n;
		logic dir;
		logic a_side_capture_clock;
		logic b_side_capture_clock;
		logic a_to_b_source_select;
		logic b_to_a_source_select;
	} rbt_ctrl_t;

	typedef struct packed {
		logic from_b;
		logic [RBT_WIDTH-1:0] data;
	} rbt_log_t;

	localparam int RBT_CTRL_W = $bits(rbt_ctrl_t);
	localparam int RBT_LOG_W = $bits(rbt_log_t);
	localparam logic [RBT_LOG_W-1:0] RBT_LOG_RST = 9'h000;

	typedef enum logic [1:0] {
		RBT_ISOLATE = 2'b00,
		RBT_DRIVE_A = 2'b01,
		RBT_DRIVE_B = 2'b10
	} rbt_mode_t;

	function automatic rbt_mode_t rbt_mode(input logic gate_n, input logic dir);
		if (gate_n) begin
			return RBT_ISOLATE;
		end
		return dir ? RBT_DRIVE_B : RBT_DRIVE_A;
	endfunction : rbt_mode

	function automatic logic [RBT_WIDTH-1:0] rbt_route(input logic [RBT_WIDTH-1:0] live,
		input logic [RBT_WIDTH-1:0] stored, input logic sel_stored, input logic inv);
		logic [RBT_WIDTH-1:0] v;
		v = sel_stored ? stored : live;
		return inv ? ~v : v;
	endfunction : rbt_route

endpackage : rbt_pkg

// ==== hdl/rbt_sync.sv ====
// Two-stage synchroniser for a vector of asynchronous pin inputs.
`timescale 1ns/1ps
module rbt_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	import rbt_pkg::*;

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_r;
	logic [W-1:0] sync_nxt;

	// The first stage feeds only the second stage.
	always_comb begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_out = sync_r;

endmodule : rbt_sync

// ==== hdl/rbt_fifo.sv ====
// Flop-based FIFO with valid/ready handshakes on both sides.
`timescale 1ns/1ps
module rbt_fifo #(
	parameter int W = 9,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	import rbt_pkg::*;

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0] mem_r [DEPTH];
	logic [W-1:0] mem_nxt [DEPTH];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic push, pop;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : ptr_inc

	assign in_ready = (cnt_r != CW'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		mem_nxt = mem_r;
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wr_r] = in_data;
			wr_nxt = ptr_inc(wr_r);
		end
		if (pop) begin
			rd_nxt = ptr_inc(rd_r);
		end
		if (push && !pop) begin
			cnt_nxt = CW'(cnt_r + 1'b1);
		end else if (pop && !push) begin
			cnt_nxt = CW'(cnt_r - 1'b1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
		mem_r <= mem_nxt;
	end

endmodule : rbt_fifo

// ==== hdl/rbt_transceiver.sv ====
// Eight-bit registered bus transceiver with per-side storage and capture log.
//
// Functional notes
// R01 - Rising capture clock stores its bus value.
// R02 - Capture ignores drive gate and direction.
// R03 - Gate high: neither bus driven, capture continues.
// R04 - Gate low, dir low: live B onto A.
// R05 - Source select high: stored B onto A.
// R06 - Dir high: live or stored A onto B.
// R07 - Never drive both buses together.
// R08 - Undriven port capturable into either register.
// R09 - Independent A and B eight-bit registers.
// R10 - No rising edge keeps register unchanged.
// R11 - Bus owner holds data stable around edges.
`timescale 1ns/1ps
module rbt_transceiver #(
	parameter bit INVERT = 1'b0,
	parameter int LOG_DEPTH = rbt_pkg::RBT_LOG_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic drive_gate_n,
	input wire logic dir,
	input wire logic a_side_capture_clock,
	input wire logic b_side_capture_clock,
	input wire logic a_to_b_source_select,
	input wire logic b_to_a_source_select,
	input wire logic [rbt_pkg::RBT_WIDTH-1:0] a_bus_in,
	output logic [rbt_pkg::RBT_WIDTH-1:0] a_bus_out,
	output logic a_bus_oe,
	input wire logic [rbt_pkg::RBT_WIDTH-1:0] b_bus_in,
	output logic [rbt_pkg::RBT_WIDTH-1:0] b_bus_out,
	output logic b_bus_oe,
	output logic [rbt_pkg::RBT_WIDTH-1:0] a_stored,
	output logic [rbt_pkg::RBT_WIDTH-1:0] b_stored,
	output logic log_valid,
	input wire logic log_ready,
	output rbt_pkg::rbt_log_t log_entry,
	output logic log_full,
	output logic overflow,
	input wire logic overflow_clear
);
	import rbt_pkg::*;

	localparam int SW = RBT_CTRL_W + 2 * RBT_WIDTH;

	// The synchroniser clears to zero, so the gate travels inverted and reads as high
	// (isolated) straight after reset instead of briefly driving the A bus.
	localparam rbt_ctrl_t IDLE_CTRL = '{drive_gate_n: 1'b1, default: 1'b0};

	rbt_ctrl_t ctrl_raw, ctrl_flip, ctrl_s;
	logic [RBT_WIDTH-1:0] bus_a_s, bus_b_s;
	logic [SW-1:0] sync_vec;

	assign ctrl_raw = '{drive_gate_n: drive_gate_n, dir: dir,
		a_side_capture_clock: a_side_capture_clock,
		b_side_capture_clock: b_side_capture_clock,
		a_to_b_source_select: a_to_b_source_select,
		b_to_a_source_select: b_to_a_source_select};

	// Data and capture clocks share one synchroniser so both see equal latency.
	rbt_sync #(
		.W(SW)
	) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in({ctrl_raw ^ IDLE_CTRL, a_bus_in, b_bus_in}),
		.sync_out(sync_vec)
	);

	assign {ctrl_flip, bus_a_s, bus_b_s} = sync_vec;
	assign ctrl_s = rbt_ctrl_t'(ctrl_flip ^ IDLE_CTRL); // R03

	// Storage and edge detection state.
	logic cpa_prev_r, cpa_prev_nxt, cpb_prev_r, cpb_prev_nxt;
	logic [RBT_WIDTH-1:0] a_reg_r, a_reg_nxt, b_reg_r, b_reg_nxt; // R09
	logic edge_a, edge_b;

	assign edge_a = ctrl_s.a_side_capture_clock && !cpa_prev_r;
	assign edge_b = ctrl_s.b_side_capture_clock && !cpb_prev_r;

	always_comb begin
		cpa_prev_nxt = ctrl_s.a_side_capture_clock;
		cpb_prev_nxt = ctrl_s.b_side_capture_clock;
		a_reg_nxt = a_reg_r; // R10
		b_reg_nxt = b_reg_r; // R10
		// Gate and direction deliberately play no part here.
		if (edge_a) begin // R02
			a_reg_nxt = bus_a_s; // R01
		end
		if (edge_b) begin
			b_reg_nxt = bus_b_s; // R01
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cpa_prev_r <= RBT_BIT_RST;
			cpb_prev_r <= RBT_BIT_RST;
			a_reg_r <= RBT_REG_RST;
			b_reg_r <= RBT_REG_RST;
		end else begin
			cpa_prev_r <= cpa_prev_nxt;
			cpb_prev_r <= cpb_prev_nxt;
			a_reg_r <= a_reg_nxt;
			b_reg_r <= b_reg_nxt;
		end
	end

	// Output drive state.
	rbt_mode_t mode;
	logic a_oe_r, a_oe_nxt, b_oe_r, b_oe_nxt;
	logic [RBT_WIDTH-1:0] a_out_r, a_out_nxt, b_out_r, b_out_nxt;

	assign mode = rbt_mode(ctrl_s.drive_gate_n, ctrl_s.dir);

	always_comb begin
		a_oe_nxt = 1'b0;
		b_oe_nxt = 1'b0;
		a_out_nxt = rbt_route(bus_b_s, b_reg_r, ctrl_s.b_to_a_source_select, INVERT); // R04 R05
		b_out_nxt = rbt_route(bus_a_s, a_reg_r, ctrl_s.a_to_b_source_select, INVERT); // R06
		// Only one enable can rise per mode, so the buses never fight.
		unique case (mode)
			RBT_ISOLATE: begin
				a_oe_nxt = 1'b0; // R03
				b_oe_nxt = 1'b0; // R03
			end
			RBT_DRIVE_A: begin
				a_oe_nxt = 1'b1; // R04 R07
			end
			RBT_DRIVE_B: begin
				b_oe_nxt = 1'b1; // R06 R07
			end
			default: begin
				a_oe_nxt = 1'b0;
				b_oe_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			a_oe_r <= RBT_BIT_RST;
			b_oe_r <= RBT_BIT_RST;
			a_out_r <= RBT_REG_RST;
			b_out_r <= RBT_REG_RST;
		end else begin
			a_oe_r <= a_oe_nxt;
			b_oe_r <= b_oe_nxt;
			a_out_r <= a_out_nxt;
			b_out_r <= b_out_nxt;
		end
	end

	// Capture log: every stored word is also queued for the user side.
	// Captures cannot be stalled, so a full FIFO drops the word and flags it.
	logic pend_r, pend_nxt;
	logic [RBT_WIDTH-1:0] pend_data_r, pend_data_nxt;
	logic push_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	rbt_log_t push_entry;
	logic [RBT_LOG_W-1:0] fifo_out_data;
	logic ovf_r, ovf_nxt, full_r, full_nxt, lv_r, lv_nxt;
	rbt_log_t le_r, le_nxt;

	always_comb begin
		pend_nxt = 1'b0;
		pend_data_nxt = pend_data_r;
		push_valid = 1'b0;
		push_entry = '{from_b: 1'b0, data: bus_a_s};
		// Synchronised edges are at least two cycles apart, so the pending slot
		// always frees before the next edge can arrive.
		if (pend_r) begin
			push_valid = 1'b1;
			push_entry = '{from_b: 1'b1, data: pend_data_r};
		end else if (edge_a) begin
			push_valid = 1'b1;
			if (edge_b) begin
				pend_nxt = 1'b1; // R08
				pend_data_nxt = bus_b_s;
			end
		end else if (edge_b) begin
			push_valid = 1'b1;
			push_entry = '{from_b: 1'b1, data: bus_b_s};
		end
		ovf_nxt = ovf_r;
		if (overflow_clear) begin
			ovf_nxt = 1'b0;
		end
		// A drop in the clearing cycle still sets the flag.
		if (push_valid && !fifo_in_ready) begin
			ovf_nxt = 1'b1;
		end
		full_nxt = !fifo_in_ready;
		fifo_out_ready = !lv_r || log_ready;
		lv_nxt = lv_r;
		le_nxt = le_r;
		if (fifo_out_ready) begin
			lv_nxt = fifo_out_valid;
			if (fifo_out_valid) begin
				le_nxt = rbt_log_t'(fifo_out_data);
			end
		end
	end

	rbt_fifo #(
		.W(RBT_LOG_W),
		.DEPTH(LOG_DEPTH)
	) u_log (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(push_valid),
		.in_ready(fifo_in_ready),
		.in_data(push_entry),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pend_r <= RBT_BIT_RST;
			pend_data_r <= RBT_REG_RST;
			ovf_r <= RBT_BIT_RST;
			full_r <= RBT_BIT_RST;
			lv_r <= RBT_BIT_RST;
			le_r <= RBT_LOG_RST;
		end else begin
			pend_r <= pend_nxt;
			pend_data_r <= pend_data_nxt;
			ovf_r <= ovf_nxt;
			full_r <= full_nxt;
			lv_r <= lv_nxt;
			le_r <= le_nxt;
		end
	end

	assign a_bus_out = a_out_r;
	assign a_bus_oe = a_oe_r;
	assign b_bus_out = b_out_r;
	assign b_bus_oe = b_oe_r;
	assign a_stored = a_reg_r;
	assign b_stored = b_reg_r;
	assign log_valid = lv_r;
	assign log_entry = le_r;
	assign log_full = full_r;
	assign overflow = ovf_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	capture_a_a: assert property (edge_a |=> a_reg_r == $past(bus_a_s)) // R01
		else $error("A register missed a capture");

	gate_indep_a: assert property ((edge_b && ctrl_s.drive_gate_n) ##1 1'b1
		|-> b_reg_r == $past(bus_b_s)) // R02
		else $error("B register capture blocked by gate");

	isolate_a: assert property (ctrl_s.drive_gate_n |=> !a_bus_oe && !b_bus_oe) // R03
		else $error("Bus driven while gate high");

	live_to_a_a: assert property ((!ctrl_s.drive_gate_n && !ctrl_s.dir
		&& !ctrl_s.b_to_a_source_select) |=> a_bus_oe
		&& a_bus_out == ($past(bus_b_s) ^ {RBT_WIDTH{INVERT}})) // R04
		else $error("Live B data not on A bus");

	stored_to_a_a: assert property ((!ctrl_s.drive_gate_n && !ctrl_s.dir
		&& ctrl_s.b_to_a_source_select) |=> a_bus_oe
		&& a_bus_out == ($past(b_reg_r) ^ {RBT_WIDTH{INVERT}})) // R05
		else $error("Stored B data not on A bus");

	drive_b_a: assert property ((!ctrl_s.drive_gate_n && ctrl_s.dir) |=> b_bus_oe && !a_bus_oe
		&& b_bus_out == ($past(ctrl_s.a_to_b_source_select ? a_reg_r : bus_a_s)
		^ {RBT_WIDTH{INVERT}})) // R06
		else $error("Wrong data or enable on B bus");

	one_driver_a: assert property (!(a_bus_oe && b_bus_oe)) // R07
		else $error("Both buses driven");

	both_capture_a: assert property ((edge_a && edge_b && !ctrl_s.drive_gate_n) |=>
		a_reg_r == $past(bus_a_s) && b_reg_r == $past(bus_b_s) ##1 pend_r == 1'b0) // R08
		else $error("Simultaneous capture lost a side");

	indep_b_a: assert property ((edge_a && !edge_b) |=> $stable(b_reg_r)) // R09
		else $error("A capture disturbed B register");

	hold_reg_a: assert property (!edge_a |=> $stable(a_reg_r)) // R10
		else $error("A register changed without an edge");

	hold_reg_b_a: assert property (!edge_b |=> $stable(b_reg_r)) // R10
		else $error("B register changed without an edge");

	// Both sides captured together must reach the log A first, then B.
	log_order_a: assert property ((edge_a && edge_b) |-> (push_valid && !push_entry.from_b)
		##1 (push_valid && push_entry.from_b)) // R08
		else $error("Simultaneous capture logged out of order");

	overflow_set_a: assert property ((push_valid && !fifo_in_ready) |=> overflow)
		else $error("Dropped capture not flagged");

	isolation_store_c: cover property (ctrl_s.drive_gate_n && edge_a && edge_b);
	stored_drive_c: cover property (!ctrl_s.drive_gate_n && ctrl_s.dir
		&& ctrl_s.a_to_b_source_select ##1 b_bus_oe);
	log_full_c: cover property (log_full ##1 overflow);
	dual_capture_c: cover property (!ctrl_s.drive_gate_n && edge_a && edge_b);
	drain_c: cover property (log_valid && log_ready ##1 !log_valid);

endmodule : rbt_transceiver

// ==== bench/rbt_bus_model.sv ====
// Far-side owners of the A and B buses, with the wire level resolved against the transceiver.
`timescale 1ns/1ps
module rbt_bus_model (
	input wire logic [7:0] a_far,
	input wire logic [7:0] b_far,
	input wire logic [7:0] a_out,
	input wire logic a_oe,
	input wire logic [7:0] b_out,
	input wire logic b_oe,
	output logic [7:0] a_wire,
	output logic [7:0] b_wire
);
	// A far owner lets go of its bus while the transceiver drives it, so no wire has two drivers.
	assign a_wire = a_oe ? a_out : a_far;
	assign b_wire = b_oe ? b_out : b_far;
endmodule : rbt_bus_model

// ==== bench/testbench.sv ====
// Self-checking bench for the registered bus transceiver.
`timescale 1ns/1ps
module testbench;
	import rbt_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic gate_n = 1'b1;
	logic dir = 1'b0;
	logic cap_a = 1'b0;
	logic cap_b = 1'b0;
	logic sel_ab = 1'b0;
	logic sel_ba = 1'b0;
	logic lrdy = 1'b0;
	logic oclr = 1'b0;
	logic [7:0] a_far = 8'h00;
	logic [7:0] b_far = 8'h00;
	logic [7:0] a_w, b_w, a_o, b_o, a_st, b_st;
	logic a_oe, b_oe, lval, lfull, ovf;
	logic [7:0] ia_o, ib_o;
	rbt_log_t lent;
	rbt_log_t exp_q[$];
	int err_count = 0;
	int cmp_count = 0;
	int n = 0;

	always #12.5 sys_clk = ~sys_clk;

	rbt_transceiver uut (.sys_clk(sys_clk), .rst(rst), .drive_gate_n(gate_n), .dir(dir),
		.a_side_capture_clock(cap_a), .b_side_capture_clock(cap_b),
		.a_to_b_source_select(sel_ab), .b_to_a_source_select(sel_ba),
		.a_bus_in(a_w), .a_bus_out(a_o), .a_bus_oe(a_oe), .b_bus_in(b_w), .b_bus_out(b_o),
		.b_bus_oe(b_oe), .a_stored(a_st), .b_stored(b_st), .log_valid(lval),
		.log_ready(lrdy), .log_entry(lent), .log_full(lfull), .overflow(ovf),
		.overflow_clear(oclr));

	rbt_bus_model far (.a_far(a_far), .b_far(b_far), .a_out(a_o), .a_oe(a_oe),
		.b_out(b_o), .b_oe(b_oe), .a_wire(a_w), .b_wire(b_w));

	// The complementing variant watches the same wires without driving them.
	rbt_transceiver #(.INVERT(1'b1)) uut_inv (.sys_clk(sys_clk), .rst(rst),
		.drive_gate_n(gate_n), .dir(dir), .a_side_capture_clock(cap_a),
		.b_side_capture_clock(cap_b), .a_to_b_source_select(sel_ab),
		.b_to_a_source_select(sel_ba), .a_bus_in(a_w), .a_bus_out(ia_o), .a_bus_oe(),
		.b_bus_in(b_w), .b_bus_out(ib_o), .b_bus_oe(), .a_stored(), .b_stored(),
		.log_valid(), .log_ready(lrdy), .log_entry(), .log_full(), .overflow(),
		.overflow_clear(oclr));

	task automatic close_out();
		$display("checks %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tick(input int k);
		repeat (k) @(negedge sys_clk);
	endtask : tick

	// Pins pass two synchroniser flops, so six cycles covers every documented latency.
	task automatic mode(input logic g, input logic d, input logic sa, input logic sb);
		tick(1);
		gate_n = g;
		dir = d;
		sel_ab = sa;
		sel_ba = sb;
		tick(6);
	endtask : mode

	// The bus is held four cycles either side of the rise so the sampled value is unambiguous.
	task automatic cap(input logic side_b, input logic [7:0] v);
		tick(1);
		if (side_b) b_far = v;
		else a_far = v;
		tick(4);
		if (side_b) cap_b = 1'b1;
		else cap_a = 1'b1;
		tick(4);
		cap_a = 1'b0;
		cap_b = 1'b0;
		tick(4);
		exp_q.push_back({side_b, v});
	endtask : cap

	initial begin
		#75000;
		err_count++;
		close_out();
	end

	initial begin
		tick(2);
		rst = 1'b0;
		tick(3);
		mode(1'b1, 1'b0, 1'b0, 1'b0);
		chk("a_oe", 9'h000, a_oe);
		chk("b_oe", 9'h000, b_oe);
		cap(1'b0, 8'h5A);
		chk("a_st", 9'h05A, a_st);
		cap(1'b1, 8'hC3);
		chk("b_st", 9'h0C3, b_st);
		chk("a_st", 9'h05A, a_st);
		mode(1'b0, 1'b0, 1'b0, 1'b0);
		chk("a_oe", 9'h001, a_oe);
		chk("b_oe", 9'h000, b_oe);
		b_far = 8'h3C;
		tick(6);
		chk("a_out", 9'h03C, a_o);
		chk("inv_a_out", 9'h0C3, ia_o);
		mode(1'b0, 1'b0, 1'b0, 1'b1);
		chk("a_out", 9'h0C3, a_o);
		chk("inv_a_out", 9'h03C, ia_o);
		mode(1'b0, 1'b1, 1'b0, 1'b0);
		chk("b_oe", 9'h001, b_oe);
		chk("a_oe", 9'h000, a_oe);
		cap(1'b0, 8'h81);
		chk("a_st", 9'h081, a_st);
		chk("b_out", 9'h081, b_o);
		a_far = 8'h18;
		tick(6);
		chk("b_out", 9'h018, b_o);
		chk("inv_b_out", 9'h0E7, ib_o);
		mode(1'b0, 1'b1, 1'b1, 1'b0);
		chk("b_out", 9'h081, b_o);
		chk("inv_b_out", 9'h07E, ib_o);
		cap_a = 1'b1;
		tick(6);
		exp_q.push_back({1'b0, 8'h18});
		a_far = 8'hE7;
		tick(6);
		chk("a_st", 9'h018, a_st);
		cap_a = 1'b0;
		tick(6);
		chk("a_st", 9'h018, a_st);
		mode(1'b1, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 6; i++) begin
			cap(i[0], 8'h20 + 8'(i));
			chk("stored", {1'b0, 8'h20 + 8'(i)}, i[0] ? b_st : a_st);
		end
		chk("log_full", 9'h001, lfull);
		chk("overflow", 9'h001, ovf);
		oclr = 1'b1;
		tick(1);
		oclr = 1'b0;
		tick(2);
		chk("overflow", 9'h000, ovf);
		// The reader stalls every third cycle; an entry is counted only when it is taken.
		for (int i = 0; i < 60; i++) begin
			tick(1);
			lrdy = (i % 3) != 0;
			if (lrdy && lval === 1'b1) begin
				n++;
				chk("log_entry", exp_q.pop_front(), lent);
			end
		end
		// The log holds its FIFO depth plus the output register; the last capture was dropped.
		chk("drained", 9'(RBT_LOG_DEPTH + 1), 9'(n));
		chk("log_valid", 9'h000, lval);
		chk("log_full", 9'h000, lfull);
		// Both capture clocks rise together while B shows the stored A word.
		mode(1'b0, 1'b1, 1'b1, 1'b0);
		a_far = 8'h99;
		tick(4);
		cap_a = 1'b1;
		cap_b = 1'b1;
		tick(4);
		cap_a = 1'b0;
		cap_b = 1'b0;
		tick(4);
		chk("a_st", 9'h099, a_st);
		chk("b_st", 9'h024, b_st);
		// A second reset must leave both buses released until the pins are seen again.
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		for (int i = 0; i < 2; i++) begin
			tick(1);
			chk("a_oe", 9'h000, a_oe);
			chk("b_oe", 9'h000, b_oe);
		end
		chk("a_st", 9'(RBT_REG_RST), a_st);
		tick(4);
		chk("b_oe", 9'h001, b_oe);
		chk("a_oe", 9'h000, a_oe);
		close_out();
	end
endmodule : testbench
